/* File: rtl/dbs_sequencer.sv */
/*
  Dynamic brake sequencer for one axis: torque-off and contactor timing, readback supervision,
  AXI4-Lite registers and interrupt. Assumes safe inputs arrive asynchronously on pins and that
  the torque-off request and restart permit come from logic on sys_clk.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module dbs_sequencer
  import dbs_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int STATIC_CYCLES = STATIC_MAX_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // safety logic side
  input wire logic torqueOffRequest,
  input wire logic restartPermit,
  output logic torqueOff,
  output logic brakeActive,
  // safe pins
  input wire logic [3:0] safeIn,
  output dbs_outs_type safeOut,
  // interrupt
  output logic irq
);

  dbs_cfg_type cfg;
  dbs_state_type state;
  dbs_state_type next_state;
  logic [IRQ_WIDTH-1:0] irqStatus;
  logic [IRQ_WIDTH-1:0] irqMask;
  logic [IRQ_WIDTH-1:0] irqEvents;
  logic [16:0] tickCnt;
  logic msTick;
  logic startSwitch;
  logic startDiag;
  logic switchDone;
  logic diagDone;
  logic contactorOn;
  logic diagActive;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] inLevel;
  logic rbLevel;
  logic rbLevelQ;
  logic rbExpected;
  logic [23:0] staticCnt;
  logic [7:0] mismatchCnt;
  logic ioErrEvt;
  logic brakeFailEvt;
  logic wrFire;
  logic rdFire;

  // millisecond tick divider
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= 17'h00000;
    end else if (tickCnt == 17'(MS_TICK_CYCLES - 1)) begin
      tickCnt <= 17'h00000;
    end else begin
      tickCnt <= tickCnt + 17'h00001;
    end
  end
  assign msTick = (tickCnt == 17'(MS_TICK_CYCLES - 1));

  // sequencing of torque-off, contactor and readback hold-off
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (torqueOffRequest && cfg.enable) begin
          next_state = ST_SWITCH_WAIT;
        end
      end
      ST_SWITCH_WAIT: begin
        if (switchDone) begin
          next_state = ST_ENGAGED;
        end
      end
      ST_ENGAGED: begin
        if (!torqueOffRequest && restartPermit) begin
          next_state = ST_RELEASE_WAIT;
        end
      end
      ST_RELEASE_WAIT: begin
        if (torqueOffRequest) begin
          next_state = ST_SWITCH_WAIT;
        end else if (switchDone) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // switch delay runs on every entry into a waiting state; diag delay on every contactor change
  assign startSwitch = (next_state != state) &&
    (next_state == ST_SWITCH_WAIT || next_state == ST_RELEASE_WAIT);
  assign startDiag = ((next_state == ST_ENGAGED) != (state == ST_ENGAGED));

  dbs_ms_timer switchTimer (.sys_clk(sys_clk), .arst_n(arst_n), .msTick(msTick), .start(startSwitch),
    .loadMs(cfg.switchMs), .expired(switchDone));

  dbs_ms_timer diagTimer (.sys_clk(sys_clk), .arst_n(arst_n), .msTick(msTick), .start(startDiag),
    .loadMs(cfg.diagMs), .expired(diagDone));

  // outputs from flip-flops; contactor and brake status follow the engaged state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      contactorOn <= 1'b0;
      torqueOff <= 1'b0;
      brakeActive <= 1'b0;
      safeOut <= '0;
    end else begin
      contactorOn <= (next_state == ST_ENGAGED);
      brakeActive <= (next_state == ST_ENGAGED);
      // without the brake configured torque-off simply follows the request
      torqueOff <= (next_state != ST_IDLE) || torqueOffRequest;
      safeOut.one <= (next_state == ST_ENGAGED);
      safeOut.two <= cfg.dual ? (next_state == ST_ENGAGED) : cfg.enable;
      safeOut.three <= cfg.dual && cfg.enable;
    end
  end

  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      inLevel <= 4'h0;
    end else begin
      sync1 <= safeIn;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 4; i++) begin
        if (sync2[i] == sync3[i]) begin
          inLevel[i] <= sync3[i];
        end
      end
    end
  end

  assign rbLevel = (cfg.rbSel == RBSEL_UNUSED) ? 1'b0 : inLevel[2'(cfg.rbSel - 3'h1)];
  assign rbExpected = contactorOn;
  // an unused readback source leaves the diagnosis off entirely
  assign diagActive = diagDone && (cfg.rbSel != RBSEL_UNUSED) && (state != ST_RELEASE_WAIT);

  // static and mismatch watchers; each reports once at its threshold, then saturates
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rbLevelQ <= 1'b0;
      staticCnt <= 24'h000000;
      mismatchCnt <= 8'h00;
    end else begin
      rbLevelQ <= rbLevel;
      if (!diagActive || !rbExpected || rbLevel != rbLevelQ) begin
        staticCnt <= 24'h000000;
      end else if (staticCnt != 24'(STATIC_CYCLES)) begin
        staticCnt <= staticCnt + 24'h000001;
      end
      if (!diagActive || rbLevel == rbExpected) begin
        mismatchCnt <= 8'h00;
      end else if (mismatchCnt != 8'(PULSE_MAX_CYCLES)) begin
        mismatchCnt <= mismatchCnt + 8'h01;
      end
    end
  end

  // test pulses shorter than the mismatch limit are tolerated
  assign ioErrEvt = diagActive && (staticCnt == 24'(STATIC_CYCLES - 1)) && (rbLevel == rbLevelQ);
  assign brakeFailEvt = diagActive && (mismatchCnt == 8'(PULSE_MAX_CYCLES - 1)) && (rbLevel != rbExpected);

  assign irqEvents = {state == ST_RELEASE_WAIT && next_state == ST_IDLE, next_state == ST_ENGAGED &&
    state != ST_ENGAGED, brakeFailEvt, ioErrEvt};

  // register bus handshakes: write address and data are taken together
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wrFire = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;

  // configuration registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg.enable <= CTRL_ENABLE_RESET;
      cfg.rbSel <= RBSEL_UNUSED;
      cfg.dual <= CTRL_DUAL_RESET;
      cfg.switchMs <= DELAY_RESET_MS;
      cfg.diagMs <= DELAY_RESET_MS;
      irqMask <= IRQ_RESET;
    end else if (wrFire) begin
      if (s_axi_awaddr == OFS_CTRL) begin
        if (s_axi_wstrb[0]) begin
          cfg.enable <= s_axi_wdata[CTRL_ENABLE_BIT];
          cfg.rbSel <= s_axi_wdata[CTRL_RBSEL_LSB +: 3];
          cfg.dual <= s_axi_wdata[CTRL_DUAL_BIT];
        end
      end else if (s_axi_awaddr == OFS_SWITCH_DELAY) begin
        cfg.switchMs <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : cfg.switchMs[15:8],
          s_axi_wstrb[0] ? s_axi_wdata[7:0] : cfg.switchMs[7:0]};
      end else if (s_axi_awaddr == OFS_DIAG_DELAY) begin
        cfg.diagMs <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : cfg.diagMs[15:8],
          s_axi_wstrb[0] ? s_axi_wdata[7:0] : cfg.diagMs[7:0]};
      end else if (s_axi_awaddr == OFS_IRQ_MASK) begin
        if (s_axi_wstrb[0]) begin
          irqMask <= s_axi_wdata[IRQ_WIDTH-1:0];
        end
      end
    end
  end

  // sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= IRQ_RESET;
    end else if (wrFire && s_axi_awaddr == OFS_IRQ_STATUS && s_axi_wstrb[0]) begin
      irqStatus <= (irqStatus & ~s_axi_wdata[IRQ_WIDTH-1:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // write response
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      if (s_axi_awaddr == OFS_CTRL || s_axi_awaddr == OFS_SWITCH_DELAY || s_axi_awaddr == OFS_DIAG_DELAY ||
          s_axi_awaddr == OFS_STATUS || s_axi_awaddr == OFS_IRQ_STATUS || s_axi_awaddr == OFS_IRQ_MASK) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data; the status word carries the I/O fail system state while a brake failure or I/O error stands, and the error code while a brake failure stands
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr == OFS_CTRL) begin
        s_axi_rdata[CTRL_ENABLE_BIT] <= cfg.enable;
        s_axi_rdata[CTRL_RBSEL_LSB +: 3] <= cfg.rbSel;
        s_axi_rdata[CTRL_DUAL_BIT] <= cfg.dual;
      end else if (s_axi_araddr == OFS_SWITCH_DELAY) begin
        s_axi_rdata[15:0] <= cfg.switchMs;
      end else if (s_axi_araddr == OFS_DIAG_DELAY) begin
        s_axi_rdata[15:0] <= cfg.diagMs;
      end else if (s_axi_araddr == OFS_STATUS) begin
        s_axi_rdata[STAT_TORQUE_OFF] <= torqueOff;
        s_axi_rdata[STAT_CONTACTOR] <= contactorOn;
        s_axi_rdata[STAT_DIAG] <= diagActive;
        s_axi_rdata[STAT_BRAKE] <= brakeActive;
        s_axi_rdata[STAT_READBACK] <= rbLevel;
        if (irqStatus[IRQ_BRAKE_FAIL] || irqStatus[IRQ_IO_ERR]) begin
          s_axi_rdata[STAT_SYS_LSB +: 4] <= SYS_STATE_IO_FAIL;
        end
        if (irqStatus[IRQ_BRAKE_FAIL]) begin
          s_axi_rdata[STAT_ERR_LSB +: 4] <= ERR_CODE_BRAKE;
        end
      end else if (s_axi_araddr == OFS_IRQ_STATUS) begin
        s_axi_rdata[IRQ_WIDTH-1:0] <= irqStatus;
      end else if (s_axi_araddr == OFS_IRQ_MASK) begin
        s_axi_rdata[IRQ_WIDTH-1:0] <= irqMask;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence restartSeen;
    state == ST_ENGAGED && !torqueOffRequest && restartPermit;
  endsequence

  sequence releasedQuiet;
    !contactorOn && !diagActive;
  endsequence

  a_restart_release: assert property (restartSeen |=> releasedQuiet)
    else $error("restart did not release contactor and suspend diagnosis");
  a_torque_holds: assert property ($fell(contactorOn) |-> torqueOff [*3])
    else $error("torque-off removed right after contactor release");
  a_diag_holdoff: assert property ($changed(contactorOn) |-> !diagActive [*2])
    else $error("diagnosis active right after contactor change");
  a_switch_after_off: assert property ($rose(contactorOn) |-> $past(torqueOff, 2) && $past(switchDone))
    else $error("contactor driven before switch delay after torque-off");
  a_diag_after_on: assert property ($rose(contactorOn) |-> !diagDone)
    else $error("diagnosis timer not restarted at switch-on");
  a_release_bound: assert property (state == ST_RELEASE_WAIT && switchDone && !torqueOffRequest
    |=> state == ST_IDLE)
    else $error("release step did not end at switch delay");
  a_delay_defaults: assert property ($rose(arst_n) |-> cfg.switchMs == 16'h0001 && cfg.diagMs == 16'h0001
    && !cfg.enable && cfg.rbSel == 3'h0)
    else $error("delay or activation defaults wrong after reset");
  a_static_error: assert property (ioErrEvt |-> rbExpected && diagActive ##1 irqStatus[IRQ_IO_ERR])
    else $error("static readback not flagged as I/O error");
  a_brake_fail: assert property (brakeFailEvt |-> rbLevel != rbExpected ##1 irqStatus[IRQ_BRAKE_FAIL])
    else $error("brake failure not latched on readback deviation");
  a_single_wiring: assert property (!cfg.dual && $stable(cfg) |-> safeOut.one == contactorOn
    && safeOut.two == cfg.enable && !safeOut.three)
    else $error("single channel outputs wrong");
  a_dual_wiring: assert property (cfg.dual && cfg.enable && $stable(cfg) |-> safeOut.one == contactorOn
    && safeOut.two == contactorOn && safeOut.three)
    else $error("dual channel outputs wrong");
  a_brake_status: assert property (brakeActive == contactorOn && (!contactorOn || torqueOff))
    else $error("brake status not tied to short with torque-off");

endmodule

/* File: rtl/dbs_pkg.sv */
/*
  Shared constants, types and register map of the dynamic brake sequencer.
  Assumes a single 100 MHz safety logic clock and a 32-bit AXI4-Lite register bus.
*/
package dbs_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PULSE_MAX_NS = 1000;
  localparam int PULSE_MAX_CYCLES = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int STATIC_MAX_NS = 5000000;
  localparam int STATIC_MAX_CYCLES = STATIC_MAX_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SWITCH_DELAY = 8'h04;
  localparam logic [7:0] OFS_DIAG_DELAY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RBSEL_LSB = 1;
  localparam int CTRL_DUAL_BIT = 4;

  // reset values
  localparam logic CTRL_ENABLE_RESET = 1'b0;
  localparam logic [2:0] RBSEL_UNUSED = 3'h0;
  localparam logic CTRL_DUAL_RESET = 1'b0;
  localparam logic [15:0] DELAY_RESET_MS = 16'h0001;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // interrupt status bits
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_IO_ERR = 0;
  localparam int IRQ_BRAKE_FAIL = 1;
  localparam int IRQ_ENGAGED = 2;
  localparam int IRQ_RELEASED = 3;

  // status register fields
  localparam int STAT_TORQUE_OFF = 0;
  localparam int STAT_CONTACTOR = 1;
  localparam int STAT_DIAG = 2;
  localparam int STAT_BRAKE = 3;
  localparam int STAT_READBACK = 4;
  localparam int STAT_SYS_LSB = 8;
  localparam int STAT_ERR_LSB = 12;
  localparam logic [3:0] SYS_STATE_IO_FAIL = 4'h8;
  localparam logic [3:0] ERR_CODE_BRAKE = 4'h2;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic [2:0] rbSel;
    logic dual;
    logic [15:0] switchMs;
    logic [15:0] diagMs;
  } dbs_cfg_type;

  typedef struct packed {
    logic one;
    logic two;
    logic three;
  } dbs_outs_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SWITCH_WAIT,
    ST_ENGAGED,
    ST_RELEASE_WAIT
  } dbs_state_type;

endpackage

/* File: rtl/dbs_ms_timer.sv */
/*
  Millisecond delay timer for the dynamic brake sequencer.
  Assumes a one-cycle millisecond tick from the caller's divider.
*/
`timescale 1ns/1ps
module dbs_ms_timer
  import dbs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // control
  input wire logic msTick,
  input wire logic start,
  input wire logic [15:0] loadMs,
  // state
  output logic expired
);

  logic [15:0] count;
  logic busy;

  // ticks are free running, so a delay of n ms lasts between n and n+1 ms, never less
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
      busy <= 1'b0;
    end else if (start) begin
      count <= loadMs;
      busy <= 1'b1;
    end else if (busy && msTick) begin
      if (count == 16'h0000) begin
        busy <= 1'b0;
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  assign expired = !busy;

endmodule

/* File: verif/dbs_contactor_model.sv */
/*
  Behavioural contactor with a test-pulsed readback contact.
  Assumes the coil and pulse source come from the sequencer's safe outputs.
*/
`timescale 1ns/1ps
module dbs_contactor_model #(
  parameter int MECH_CYCLES = 10,
  parameter int PULSE_PERIOD = 50,
  parameter int PULSE_LOW = 4
) (
  // clock
  input wire logic sys_clk,
  // coil side
  input wire logic coilOn,
  input wire logic pulseSrc,
  // fault injection
  input wire logic stuckHigh,
  // readback contact
  output logic readback
);
  int mechCnt = 0;
  int phase = 0;
  logic closed = 1'b0;

  // contact lags the coil by a mechanical delay
  always @(posedge sys_clk) begin
    if (coilOn != closed) begin
      mechCnt <= mechCnt + 1;
      if (mechCnt >= MECH_CYCLES) begin
        closed <= coilOn;
        mechCnt <= 0;
      end
    end else begin
      mechCnt <= 0;
    end
    phase <= (phase + 1) % PULSE_PERIOD;
  end

  // short low test pulses; an open contact reads as pulled low
  always_comb begin
    readback = stuckHigh | (closed & pulseSrc & (phase >= PULSE_LOW));
  end
endmodule

/* File: verif/dbs_sequencer_tb.sv */
/*
  Self-checking bench of the dynamic brake sequencer with a contactor model.
  Assumes shortened ms tick and static limit parameters on the design.
*/
`timescale 1ns/1ps
module dbs_sequencer_tb
  import dbs_pkg::*;
;
  localparam int TICK = 20;
  localparam int STATIC = 200;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic torqueOffRequest = 1'b0;
  logic restartPermit = 1'b0;
  logic [2:0] safeInRand = 3'h0;
  logic stuckHigh = 1'b0;
  logic dualSel = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic torqueOff, brakeActive, irq, readback;
  dbs_outs_type safeOut;
  logic [31:0] seed = 32'h0000FC15;
  logic [31:0] pinSeed = 32'h0000FC15;
  int cycles = 0;
  int num_errors = 0;
  int cmp_count = 0;

  dbs_sequencer #(.MS_TICK_CYCLES(TICK), .STATIC_CYCLES(STATIC)) u_dbs_sequencer (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .torqueOffRequest(torqueOffRequest), .restartPermit(restartPermit), .torqueOff(torqueOff),
    .brakeActive(brakeActive), .safeIn({safeInRand, readback}), .safeOut(safeOut), .irq(irq));

  // dual wiring puts both channels in series with the coil
  dbs_contactor_model u_dbs_contactor_model (
    .sys_clk(sys_clk), .coilOn(safeOut.one & (safeOut.two | ~dualSel)),
    .pulseSrc(dualSel ? safeOut.three : safeOut.two), .stuckHigh(stuckHigh), .readback(readback));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // unused readback sources toggle at random; also the hang limit
  always @(posedge sys_clk) begin
    pinSeed <= lfsr(pinSeed);
    safeInRand <= pinSeed[2:0];
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_neg(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // write: address and data offered together, held until taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, d & m, e);
    check("rresp", 32'(r), 32'(RESP_OKAY));
  endtask

  // one engage and restart sequence with random delays
  task automatic run_cycle(input logic dual);
    logic [15:0] sw;
    logic [15:0] dg;
    logic [1:0] r;
    int t0;
    seed = lfsr(seed);
    sw = 16'(1 + seed[7:0] % 3);
    dg = 16'(1 + seed[15:8] % 3);
    dualSel <= dual;
    axi_write(OFS_SWITCH_DELAY, {16'h0, sw}, r);
    axi_write(OFS_DIAG_DELAY, {16'h0, dg}, r);
    axi_write(OFS_CTRL, {27'h0, dual, 3'h1, 1'b1}, r);
    wait_neg((dg + 2) * TICK);
    @(posedge sys_clk);
    torqueOffRequest <= 1'b1;
    restartPermit <= 1'b0;
    t0 = cycles;
    wait_neg(2);
    check("torqueOff", 32'(torqueOff), 1);
    while (safeOut.one !== 1'b1 && cycles - t0 < 400) @(negedge sys_clk);
    check("switch delay", 32'(cycles - t0 >= sw * TICK - 2 && cycles - t0 <= (sw + 1) * TICK + 3), 1);
    check("outs", {29'h0, safeOut}, {29'h0, 2'b11, dual});
    check("brakeActive", 32'(brakeActive), 1);
    rd_chk("diag held", OFS_STATUS, 32'h4, 32'h0);
    wait_neg(dg * TICK - 14);
    rd_chk("diag late", OFS_STATUS, 32'h4, 32'h0);
    wait_neg(30);
    rd_chk("engaged", OFS_STATUS, 32'hF, 32'hF);
    @(posedge sys_clk);
    torqueOffRequest <= 1'b0;
    restartPermit <= 1'b1;
    t0 = cycles;
    wait_neg(2);
    check("released", {31'h0, safeOut.one}, 0);
    check("torqueOff held", 32'(torqueOff), 1);
    rd_chk("diag off", OFS_STATUS, 32'h6, 32'h0);
    while (torqueOff !== 1'b0 && cycles - t0 < 400) @(negedge sys_clk);
    check("restart delay", 32'(cycles - t0 >= sw * TICK - 2 && cycles - t0 <= (sw + 1) * TICK + 3), 1);
    wait_neg(((sw > dg) ? sw : dg) * TICK + 2 * TICK);
    rd_chk("diag back", OFS_STATUS, 32'hF, 32'h4);
    rd_chk("events", OFS_IRQ_STATUS, 32'hC, 32'hC);
    axi_write(OFS_IRQ_STATUS, 32'hC, r);
    rd_chk("events clear", OFS_IRQ_STATUS, 32'hF, 32'h0);
    $display("test cycle dual=%0d done", dual);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    // reset values, unmapped place, register round trip
    rd_chk("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk("switch", OFS_SWITCH_DELAY, 32'hFFFF, 32'h1);
    rd_chk("diag", OFS_DIAG_DELAY, 32'hFFFF, 32'h1);
    rd_chk("mask", OFS_IRQ_MASK, 32'hF, 32'h0);
    axi_read(8'h18, d, r);
    check("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
    check("unmapped rdata", d, 32'h0);
    axi_write(8'h18, 32'hFFFF, r);
    check("unmapped bresp", 32'(r), 32'(RESP_SLVERR));
    seed = lfsr(seed);
    axi_write(OFS_DIAG_DELAY, seed, r);
    rd_chk("delay rw", OFS_DIAG_DELAY, 32'hFFFF, {16'h0, seed[15:0]});
    $display("test reset done");
    // never-active brake: torque-off alone
    @(posedge sys_clk);
    torqueOffRequest <= 1'b1;
    wait_neg(3 * TICK);
    check("off torqueOff", 32'(torqueOff), 1);
    check("off outs", {29'h0, safeOut}, 32'h0);
    @(posedge sys_clk);
    torqueOffRequest <= 1'b0;
    wait_neg(3);
    check("off restart", 32'(torqueOff), 0);
    run_cycle(1'b0);
    // readback high while brake is off, masked then unmasked
    axi_write(OFS_IRQ_MASK, 32'h0, r);
    @(posedge sys_clk);
    stuckHigh <= 1'b1;
    wait_neg(150);
    rd_chk("brake fail", OFS_IRQ_STATUS, 32'h3, 32'h2);
    rd_chk("fail code", OFS_STATUS, 32'hFF10, 32'h2810);
    check("irq masked", 32'(irq), 0);
    axi_write(OFS_IRQ_MASK, 32'h2, r);
    wait_neg(2);
    check("irq", 32'(irq), 1);
    @(posedge sys_clk);
    stuckHigh <= 1'b0;
    wait_neg(150);
    axi_write(OFS_IRQ_STATUS, 32'hF, r);
    wait_neg(2);
    check("irq clear", 32'(irq), 0);
    rd_chk("fail clear", OFS_STATUS, 32'hFF00, 32'h0);
    $display("test brake failure done");
    run_cycle(1'b1);
    // static readback while engaged
    @(posedge sys_clk);
    stuckHigh <= 1'b1;
    torqueOffRequest <= 1'b1;
    restartPermit <= 1'b0;
    wait_neg(8 * TICK + STATIC + 60);
    rd_chk("io error", OFS_IRQ_STATUS, 32'h1, 32'h1);
    rd_chk("io state", OFS_STATUS, 32'hF00, 32'h800);
    $display("test io error done");
    end_sim();
  end
endmodule
